// *** fdcp_link.sv ***
`timescale 1ns/1ns
module fdcp_link (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic shift_clk_i,
	input wire logic clk_bit_i,
	input wire logic data_bit_i,
	input wire logic [3:0] pattern_i,
	output logic shift_edge_o,
	output logic rx_bit_o,
	output logic [7:0] rx_byte_o,
	output logic rx_ready_o,
	output logic [7:0] am_byte_o,
	output logic am_match_o
);
	// Index 0 shift clock, 1 recovered clock, 2 recovered data
	logic [2:0] raw;
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] sync3;
	logic [2:0] filt;
	logic shift_prev;
	logic [7:0] data_sr;
	logic [7:0] clk_sr;
	logic [2:0] bit_cnt;

	assign raw = {data_bit_i, clk_bit_i, shift_clk_i};

	// Shift clock idles high, so its chain resets high to avoid a false edge
	for (genvar i = 0; i < 3; i++) begin : g_sync
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				sync1[i] <= (i == 0);
				sync2[i] <= (i == 0);
				sync3[i] <= (i == 0);
				filt[i] <= (i == 0);
			end else begin
				sync1[i] <= raw[i];
				sync2[i] <= sync1[i];
				sync3[i] <= sync2[i];
				if (sync2[i] == sync3[i]) begin
					filt[i] <= sync3[i];
				end
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			shift_prev <= 1'b1;
		end else begin
			shift_prev <= filt[0];
		end
	end

	assign shift_edge_o = filt[0] & ~shift_prev;
	assign rx_bit_o = filt[2];

	// Deserialiser: data and clock bits taken on each rising shift edge
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			data_sr <= 8'h00;
			clk_sr <= 8'h00;
			bit_cnt <= 3'h0;
			rx_byte_o <= 8'h00;
			rx_ready_o <= 1'b0;
			am_byte_o <= 8'h00;
			am_match_o <= 1'b0;
		end else begin
			rx_ready_o <= 1'b0;
			am_match_o <= 1'b0;
			if (shift_edge_o) begin
				data_sr <= {data_sr[6:0], filt[2]};
				clk_sr <= {clk_sr[6:0], filt[1]};
				if ({clk_sr[2:0], filt[1]} == pattern_i) begin
					// Address mark realigns the byte boundary
					am_match_o <= 1'b1;
					am_byte_o <= {data_sr[6:0], filt[2]};
					bit_cnt <= 3'h0;
				end else begin
					bit_cnt <= bit_cnt + 3'h1;
					if (bit_cnt == 3'h7) begin
						rx_ready_o <= 1'b1;
						rx_byte_o <= {data_sr[6:0], filt[2]};
					end
				end
			end
		end
	end

endmodule : fdcp_link

// *** fdcp_pkg.sv ***
package fdcp_pkg;

	// Clock and rates
	localparam int CLK_HZ = 25_000_000;
	localparam int FM_BIT_HZ = 125_000;
	localparam int MFM_BIT_HZ = 250_000;
	localparam int FM_BIT_CYC = CLK_HZ / FM_BIT_HZ;
	localparam int MFM_BIT_CYC = CLK_HZ / MFM_BIT_HZ;
	localparam int REF_CLK_HZ = 2_000_000;
	// Phase accumulator: toggles at twice the reference rate, in MHz units
	localparam int REF_ACC_STEP = 2 * REF_CLK_HZ / 1_000_000;
	localparam int REF_ACC_MOD = CLK_HZ / 1_000_000;
	localparam int HEAD_LOAD_MS = 500;
	localparam int HEAD_LOAD_CYC = (CLK_HZ / 1000) * HEAD_LOAD_MS;
	localparam int WAIT_TIMEOUT_US = 1000;
	localparam int WAIT_TIMEOUT_CYC = (CLK_HZ / 1_000_000) * WAIT_TIMEOUT_US;

	// Address map
	localparam logic [15:0] ROM_BASE = 16'hE000;
	localparam logic [15:0] ROM_LAST = 16'hE7FF;
	localparam logic [15:0] RAM_BASE = 16'hE800;
	localparam logic [15:0] RAM_LAST = 16'hE8FF;
	localparam logic [15:0] ADDR_WRITE_CRC = 16'hE900;
	localparam logic [15:0] ADDR_SENSE_PRI = 16'hE901;
	localparam logic [15:0] ADDR_MOTION = 16'hE902;
	localparam logic [15:0] ADDR_CFG_A = 16'hE903;
	localparam logic [15:0] ADDR_SENSE_SEC = 16'hEA00;
	localparam logic [15:0] ADDR_THIRD = 16'hEA01;
	localparam logic [15:0] ADDR_DENSITY = 16'hEA02;
	localparam logic [15:0] ADDR_CFG_B = 16'hEA03;
	localparam logic [15:0] ADDR_AM_READ = 16'hEB00;
	localparam logic [15:0] ADDR_BYTE_READ = 16'hED00;
	localparam logic [15:0] ADDR_BYTE_WRITE = 16'hEE00;
	localparam logic [15:0] ADDR_HEAD_LOAD = 16'hEF00;

	// Write/CRC control port fields
	localparam int WC_CRC_EN = 0;
	localparam int WC_PAT0 = 1;
	localparam int WC_SYNC = 2;
	localparam int WC_PAT3 = 3;
	localparam int WC_WGATE = 4;
	localparam int WC_PRE_LO = 5;
	localparam int WC_PRE_HI = 6;
	localparam int WC_CRC_OUT = 7;
	// Motion/select control port fields
	localparam int MS_STEP = 0;
	localparam int MS_SEL_LO = 1;
	localparam int MS_SEL_HI = 3;
	localparam int MS_MOTOR = 4;
	localparam int MS_DIR = 5;
	localparam int MS_PAT1 = 6;
	localparam int MS_CRC_PRESET = 7;
	// Third control port field feeding pattern bit 2
	localparam int TC_PAT2 = 0;
	// Density/side control port fields
	localparam int DS_SEL4 = 0;
	localparam int DS_DEN_HI = 2;
	localparam int DS_DEN_LO = 3;
	localparam int DS_SIDE = 7;
	// Secondary sense port fields
	localparam int SS_HEAD = 0;
	localparam int SS_CRC = 1;

	// Reset and fixed values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] UNDEF_DATA = 8'hFF;
	localparam logic [15:0] CRC_PRESET = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [1:0] DEN_FM = 2'h0;
	localparam logic [1:0] DEN_MFM = 2'h1;

	typedef enum logic [1:0] {ST_IDLE, ST_AM, ST_RD, ST_WR} fdcp_state_type;

endpackage : fdcp_pkg

// *** fdcp_sep_model.sv ***
`timescale 1ns/1ns
module fdcp_sep_model (
	output logic shift_o,
	output logic clk_bit_o,
	output logic data_bit_o
);
	// Raw drive line into the separator: low pulse per one bit, idles high
	logic standard_drive_raw_data = 1'b1;
	// Shift clock rests high between frames
	initial begin
		shift_o = 1'b1;
		clk_bit_o = 1'b0;
		data_bit_o = 1'b1;
	end
	// One byte, MSB first, bits change while shift clock is low
	task automatic send(input logic [7:0] c, input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			shift_o = 1'b0;
			clk_bit_o = c[i];
			data_bit_o = d[i];
			standard_drive_raw_data = ~d[i];
			#160 shift_o = 1'b1;
			standard_drive_raw_data = 1'b1;
			#160;
		end
		clk_bit_o = ~clk_bit_o;
		data_bit_o = ~data_bit_o;
	endtask : send
endmodule : fdcp_sep_model

// *** fdcp_top.sv ***
`timescale 1ns/1ns
// What this block does
// - ROM of 2048 bytes answers host reads at E000 to E7FF.
// - Scratch RAM of 256 bytes reads and writes at E800 to E8FF.
// - Write/CRC port bit 0 enables CRC, bit 7 sends CRC onto write data.
// - Mark pattern bits 0 and 3 from write/CRC port, bit 1 from motion port.
// - Write/CRC port bit 2 drives separator sync, bit 4 the write gate.
// - Write/CRC port bits 6:5 select precompensation group.
// - Primary sense: protect, option switches, ready, track zero, index.
// - Motion port drives step, selects 1-3, motor on, direction.
// - Motion port bit 7 presets the CRC to all ones.
// - Secondary sense: bit 0 head-load active, bit 1 CRC error.
// - Any write to HEAD_LOAD_TRIGGER retriggers the head-load one-shot.
// - Density port: select 4, side select, density field bits 2 and 3.
// - Mark read waits for clock pattern match, returns its data byte.
// - Byte read waits for next deserialised byte, then returns it.
// - Byte write waits until the hold byte is empty, then loads the byte into it.
// - Data and clock shift in on each rising shift clock edge.
// - Device sends a 2 MHz reference clock to the separator.
// - Two format lines to separator: 00 FM 125k, 01 MFM 250k.
// - Every wait stall ends no later than a retriggered timeout.
module fdcp_top #(
	parameter int HEAD_LOAD_CYCLES = fdcp_pkg::HEAD_LOAD_CYC,
	parameter int WAIT_TIMEOUT_CYCLES = fdcp_pkg::WAIT_TIMEOUT_CYC,
	parameter logic [7:0] ROM_FILL = 8'hFF
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic rd_i,
	input wire logic wr_i,
	output logic [7:0] rdata_o,
	output logic ack_o,
	output logic wait_o,
	input wire logic write_protect_n_i,
	input wire logic [3:0] option_sw_i,
	input wire logic drive_ready_n_i,
	input wire logic track_zero_flag_n_i,
	input wire logic index_n_i,
	input wire logic separator_shift_clock_i,
	input wire logic sep_clk_bit_i,
	input wire logic sep_data_bit_i,
	output logic sep_sync_o,
	output logic ref_clk_o,
	output logic [1:0] format_sel_o,
	output logic write_gate_o,
	output logic write_data_o,
	output logic [1:0] precomp_sel_o,
	output logic step_o,
	output logic [3:0] drive_sel_o,
	output logic motor_on_o,
	output logic direction_o,
	output logic side_sel_o,
	output logic [7:0] third_ctrl_o
);
	localparam int HL_W = $clog2(HEAD_LOAD_CYCLES + 1);
	localparam int TO_W = $clog2(WAIT_TIMEOUT_CYCLES + 1);

	fdcp_pkg::fdcp_state_type state;
	logic take;
	logic rd_take;
	logic wr_take;
	logic [7:0] write_crc_control_port;
	logic [7:0] motion_select_control_port;
	logic [7:0] density_side_control_port;
	logic [7:0] ram_mem [0:255];
	logic [7:0] next_rdata;
	logic [7:0] sense_raw;
	logic [7:0] sense_s1;
	logic [7:0] sense_s2;
	logic [7:0] sense_s3;
	logic [7:0] primary_sense_port;
	logic [7:0] secondary_sense_port;
	logic [HL_W-1:0] head_left;
	logic [TO_W-1:0] tmo_left;
	logic timed_out;
	logic [4:0] ref_acc;
	logic [7:0] bit_div;
	logic bit_tick;
	logic [2:0] tx_cnt;
	logic [7:0] tx_sr;
	logic [7:0] tx_src;
	logic [7:0] hold_byte;
	logic hold_full;
	logic [7:0] wr_byte;
	logic [15:0] crc;
	logic [3:0] pattern;
	logic shift_edge;
	logic rx_bit;
	logic [7:0] rx_byte;
	logic rx_ready;
	logic [7:0] am_byte;
	logic am_match;

	assign take = (rd_i | wr_i) & (state == fdcp_pkg::ST_IDLE) & ~ack_o;
	assign rd_take = take & rd_i;
	assign wr_take = take & wr_i & ~rd_i;

	fdcp_link u_link (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.shift_clk_i(separator_shift_clock_i),
		.clk_bit_i(sep_clk_bit_i),
		.data_bit_i(sep_data_bit_i),
		.pattern_i(pattern),
		.shift_edge_o(shift_edge),
		.rx_bit_o(rx_bit),
		.rx_byte_o(rx_byte),
		.rx_ready_o(rx_ready),
		.am_byte_o(am_byte),
		.am_match_o(am_match)
	);

	// Clock recognition pattern
	assign pattern = {write_crc_control_port[fdcp_pkg::WC_PAT3],
		third_ctrl_o[fdcp_pkg::TC_PAT2],
		motion_select_control_port[fdcp_pkg::MS_PAT1],
		write_crc_control_port[fdcp_pkg::WC_PAT0]};

	// Drive status pins, three-stage synchronised
	assign sense_raw = {index_n_i, track_zero_flag_n_i, drive_ready_n_i, option_sw_i,
		write_protect_n_i};
	for (genvar i = 0; i < 8; i++) begin : g_sense
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				sense_s1[i] <= 1'b1;
				sense_s2[i] <= 1'b1;
				sense_s3[i] <= 1'b1;
				primary_sense_port[i] <= 1'b1;
			end else begin
				sense_s1[i] <= sense_raw[i];
				sense_s2[i] <= sense_s1[i];
				sense_s3[i] <= sense_s2[i];
				if (sense_s2[i] == sense_s3[i]) begin
					primary_sense_port[i] <= sense_s3[i];
				end
			end
		end
	end

	assign secondary_sense_port = {6'h00, |crc, head_left != '0};

	// Control port writes; a configuration write clears its group
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			write_crc_control_port <= fdcp_pkg::CTRL_RESET;
			motion_select_control_port <= fdcp_pkg::CTRL_RESET;
			third_ctrl_o <= fdcp_pkg::CTRL_RESET;
			density_side_control_port <= fdcp_pkg::CTRL_RESET;
		end else if (wr_take) begin
			unique case (addr_i)
				fdcp_pkg::ADDR_WRITE_CRC: write_crc_control_port <= wdata_i;
				fdcp_pkg::ADDR_MOTION: motion_select_control_port <= wdata_i;
				fdcp_pkg::ADDR_THIRD: third_ctrl_o <= wdata_i;
				fdcp_pkg::ADDR_DENSITY: density_side_control_port <= wdata_i;
				fdcp_pkg::ADDR_CFG_A: begin
					write_crc_control_port <= fdcp_pkg::CTRL_RESET;
					motion_select_control_port <= fdcp_pkg::CTRL_RESET;
				end
				fdcp_pkg::ADDR_CFG_B: begin
					third_ctrl_o <= fdcp_pkg::CTRL_RESET;
					density_side_control_port <= fdcp_pkg::CTRL_RESET;
				end
				default: ;
			endcase
		end
	end

	assign sep_sync_o = write_crc_control_port[fdcp_pkg::WC_SYNC];
	assign write_gate_o = write_crc_control_port[fdcp_pkg::WC_WGATE];
	assign precomp_sel_o = write_crc_control_port[fdcp_pkg::WC_PRE_HI:fdcp_pkg::WC_PRE_LO];
	assign step_o = motion_select_control_port[fdcp_pkg::MS_STEP];
	assign motor_on_o = motion_select_control_port[fdcp_pkg::MS_MOTOR];
	assign direction_o = motion_select_control_port[fdcp_pkg::MS_DIR];
	assign drive_sel_o = {density_side_control_port[fdcp_pkg::DS_SEL4],
		motion_select_control_port[fdcp_pkg::MS_SEL_HI:fdcp_pkg::MS_SEL_LO]};
	assign side_sel_o = density_side_control_port[fdcp_pkg::DS_SIDE];
	assign format_sel_o = {density_side_control_port[fdcp_pkg::DS_DEN_HI],
		density_side_control_port[fdcp_pkg::DS_DEN_LO]};

	// Scratch RAM
	always_ff @(posedge clk_i) begin
		if (wr_take && addr_i >= fdcp_pkg::RAM_BASE && addr_i <= fdcp_pkg::RAM_LAST) begin
			ram_mem[addr_i[7:0]] <= wdata_i;
		end
	end

	// Head-load one-shot, restarted by any write to its location
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			head_left <= '0;
		end else if (wr_take && addr_i == fdcp_pkg::ADDR_HEAD_LOAD) begin
			head_left <= HL_W'(HEAD_LOAD_CYCLES);
		end else if (head_left != '0) begin
			head_left <= head_left - HL_W'(1);
		end
	end

	// 2 MHz reference from a fractional phase accumulator
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ref_acc <= 5'h00;
			ref_clk_o <= 1'b0;
		end else if (ref_acc + 5'(fdcp_pkg::REF_ACC_STEP) >= 5'(fdcp_pkg::REF_ACC_MOD)) begin
			ref_acc <= ref_acc + 5'(fdcp_pkg::REF_ACC_STEP) - 5'(fdcp_pkg::REF_ACC_MOD);
			ref_clk_o <= ~ref_clk_o;
		end else begin
			ref_acc <= ref_acc + 5'(fdcp_pkg::REF_ACC_STEP);
		end
	end

	// Bit-cell enable while writing, rate from density field
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bit_div <= 8'h00;
			bit_tick <= 1'b0;
		end else if (!write_gate_o) begin
			bit_div <= 8'h00;
			bit_tick <= 1'b0;
		end else begin
			bit_tick <= 1'b0;
			if (bit_div == ((format_sel_o == fdcp_pkg::DEN_MFM) ?
					8'(fdcp_pkg::MFM_BIT_CYC - 1) : 8'(fdcp_pkg::FM_BIT_CYC - 1))) begin
				bit_div <= 8'h00;
				bit_tick <= 1'b1;
			end else begin
				bit_div <= bit_div + 8'h01;
			end
		end
	end

	// Serialiser: a new byte loads at each byte boundary
	assign tx_src = (tx_cnt != 3'h0) ? tx_sr : (hold_full ? hold_byte : 8'h00);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_cnt <= 3'h0;
			tx_sr <= 8'h00;
			write_data_o <= 1'b0;
		end else if (!write_gate_o) begin
			tx_cnt <= 3'h0;
			write_data_o <= 1'b0;
		end else if (bit_tick) begin
			tx_cnt <= tx_cnt + 3'h1;
			tx_sr <= {tx_src[6:0], 1'b0};
			write_data_o <= write_crc_control_port[fdcp_pkg::WC_CRC_OUT] ? crc[15] : tx_src[7];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hold_full <= 1'b0;
			hold_byte <= 8'h00;
		end else if (write_gate_o && bit_tick && tx_cnt == 3'h0 && hold_full) begin
			hold_full <= 1'b0;
		end else if (state == fdcp_pkg::ST_WR && !hold_full && !timed_out) begin
			hold_full <= 1'b1;
			hold_byte <= wr_byte;
		end
	end

	// CRC-16 over written or received data bits
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? fdcp_pkg::CRC_POLY : 16'h0000);
	endfunction : crc_step

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			crc <= fdcp_pkg::CRC_PRESET;
		end else if (wr_take && addr_i == fdcp_pkg::ADDR_MOTION && wdata_i[fdcp_pkg::MS_CRC_PRESET]) begin
			crc <= fdcp_pkg::CRC_PRESET;
		end else if (write_crc_control_port[fdcp_pkg::WC_CRC_EN]) begin
			if (write_gate_o && bit_tick) begin
				crc <= write_crc_control_port[fdcp_pkg::WC_CRC_OUT] ?
					{crc[14:0], 1'b0} : crc_step(crc, tx_src[7]);
			end else if (!write_gate_o && shift_edge) begin
				crc <= crc_step(crc, rx_bit);
			end
		end
	end

	// Immediate read data
	always_comb begin
		next_rdata = fdcp_pkg::UNDEF_DATA;
		if (addr_i <= fdcp_pkg::ROM_LAST && addr_i >= fdcp_pkg::ROM_BASE) begin
			next_rdata = ROM_FILL;
		end else if (addr_i >= fdcp_pkg::RAM_BASE && addr_i <= fdcp_pkg::RAM_LAST) begin
			next_rdata = ram_mem[addr_i[7:0]];
		end else if (addr_i == fdcp_pkg::ADDR_SENSE_PRI) begin
			next_rdata = primary_sense_port;
		end else if (addr_i == fdcp_pkg::ADDR_SENSE_SEC) begin
			next_rdata = secondary_sense_port;
		end
	end

	assign timed_out = (state != fdcp_pkg::ST_IDLE) && tmo_left == '0;

	// Host access sequencer with wait-state synchronisation
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= fdcp_pkg::ST_IDLE;
			ack_o <= 1'b0;
			wait_o <= 1'b0;
			rdata_o <= 8'h00;
			wr_byte <= 8'h00;
			tmo_left <= '0;
		end else begin
			ack_o <= 1'b0;
			if (take) begin
				tmo_left <= TO_W'(WAIT_TIMEOUT_CYCLES);
				wr_byte <= wdata_i;
				if (rd_i && addr_i == fdcp_pkg::ADDR_AM_READ) begin
					state <= fdcp_pkg::ST_AM;
					wait_o <= 1'b1;
				end else if (rd_i && addr_i == fdcp_pkg::ADDR_BYTE_READ) begin
					state <= fdcp_pkg::ST_RD;
					wait_o <= 1'b1;
				end else if (!rd_i && addr_i == fdcp_pkg::ADDR_BYTE_WRITE) begin
					state <= fdcp_pkg::ST_WR;
					wait_o <= 1'b1;
				end else begin
					ack_o <= 1'b1;
					rdata_o <= rd_i ? next_rdata : rdata_o;
				end
			end else if (state != fdcp_pkg::ST_IDLE) begin
				tmo_left <= tmo_left - TO_W'(1);
				if ((state == fdcp_pkg::ST_AM && am_match) ||
						(state == fdcp_pkg::ST_RD && rx_ready) ||
						(state == fdcp_pkg::ST_WR && !hold_full) || timed_out) begin
					state <= fdcp_pkg::ST_IDLE;
					wait_o <= 1'b0;
					ack_o <= 1'b1;
					unique case (state)
						fdcp_pkg::ST_AM: rdata_o <= timed_out ? fdcp_pkg::UNDEF_DATA : am_byte;
						fdcp_pkg::ST_RD: rdata_o <= timed_out ? fdcp_pkg::UNDEF_DATA : rx_byte;
						fdcp_pkg::ST_WR: rdata_o <= rdata_o;
						fdcp_pkg::ST_IDLE: rdata_o <= rdata_o;
					endcase
				end
			end
		end
	end

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic [TO_W:0] stall_len;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			stall_len <= '0;
		end else begin
			stall_len <= wait_o ? stall_len + (TO_W + 1)'(1) : '0;
		end
	end

	a_stall_bounded: assert property (stall_len <= (TO_W + 1)'(WAIT_TIMEOUT_CYCLES + 1))
		else $error("wait stall exceeded timeout");
	a_rom_read_data: assert property (rd_take && addr_i >= fdcp_pkg::ROM_BASE &&
		addr_i <= fdcp_pkg::ROM_LAST |=> ack_o && rdata_o == ROM_FILL && !wait_o)
		else $error("ROM read not answered next cycle");
	a_ram_round_trip: assert property (wr_take && addr_i >= fdcp_pkg::RAM_BASE &&
		addr_i <= fdcp_pkg::RAM_LAST ##3 rd_take && addr_i == $past(addr_i, 3) |=>
		rdata_o == $past(wdata_i, 4))
		else $error("RAM did not return written byte");
	a_wgate_follow: assert property (wr_take && addr_i == fdcp_pkg::ADDR_WRITE_CRC |=>
		write_gate_o == $past(wdata_i[4]) && sep_sync_o == $past(wdata_i[2]))
		else $error("write gate or sync not from control port");
	a_motion_lines: assert property (wr_take && addr_i == fdcp_pkg::ADDR_MOTION |=>
		drive_sel_o[2:0] == $past(wdata_i[3:1]) && direction_o == $past(wdata_i[5]))
		else $error("motion port lines wrong");
	a_crc_preset: assert property (wr_take && addr_i == fdcp_pkg::ADDR_MOTION && wdata_i[7] |=>
		crc == fdcp_pkg::CRC_PRESET)
		else $error("CRC not preset");
	a_head_retrig: assert property (wr_take && addr_i == fdcp_pkg::ADDR_HEAD_LOAD |=>
		##1 secondary_sense_port[0] && head_left == HL_W'(HEAD_LOAD_CYCLES - 1))
		else $error("head-load one-shot not retriggered");
	a_byte_read_data: assert property (state == fdcp_pkg::ST_RD && rx_ready && !timed_out |=>
		ack_o && !wait_o && rdata_o == $past(rx_byte))
		else $error("byte read did not return received byte");
	a_mark_read_data: assert property (state == fdcp_pkg::ST_AM && am_match && !timed_out |=>
		ack_o && rdata_o == $past(am_byte))
		else $error("mark read did not return mark byte");
	a_write_accept: assert property (state == fdcp_pkg::ST_WR && !hold_full && !timed_out |=>
		ack_o && hold_full && hold_byte == $past(wr_byte))
		else $error("byte write not accepted");
	a_format_lines: assert property (wr_take && addr_i == fdcp_pkg::ADDR_DENSITY |=>
		format_sel_o == {$past(wdata_i[2]), $past(wdata_i[3])})
		else $error("format lines not from density field");

	c_mark_read: cover property (state == fdcp_pkg::ST_AM && am_match);
	c_byte_write: cover property (state == fdcp_pkg::ST_WR ##1 ack_o);
	c_timeout: cover property (timed_out);

endmodule : fdcp_top

// *** tb.sv ***
`timescale 1ns/1ns
module tb;
	logic clk_i = 1'b0, rst_i = 1'b1, rd_i = 1'b0, wr_i = 1'b0;
	logic [15:0] addr_i = 16'h0000;
	logic [7:0] wdata_i = 8'h00, rdata_o, q, third;
	logic ack_o, wait_o, wp_n = 1'b1, rdy_n = 1'b1, tz_n = 1'b1, idx_n = 1'b1, pr;
	logic sclk, cbit, dbit, sync_w, ref_w, wg_w, wd_w, step_w, mot_w, dir_w, side_w;
	logic [3:0] opt = 4'h0, dsel;
	logic [1:0] fmt, pre;
	logic [31:0] rnd = 32'h116B9B48;
	int mismatches = 0, n_compared = 0, cyc, k;

	always #20 clk_i = ~clk_i;

	fdcp_sep_model sep (.shift_o(sclk), .clk_bit_o(cbit), .data_bit_o(dbit));

	fdcp_top #(.HEAD_LOAD_CYCLES(50), .WAIT_TIMEOUT_CYCLES(2000)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .rd_i(rd_i),
		.wr_i(wr_i), .rdata_o(rdata_o), .ack_o(ack_o), .wait_o(wait_o),
		.write_protect_n_i(wp_n), .option_sw_i(opt), .drive_ready_n_i(rdy_n),
		.track_zero_flag_n_i(tz_n), .index_n_i(idx_n), .separator_shift_clock_i(sclk),
		.sep_clk_bit_i(cbit), .sep_data_bit_i(dbit), .sep_sync_o(sync_w), .ref_clk_o(ref_w),
		.format_sel_o(fmt), .write_gate_o(wg_w), .write_data_o(wd_w), .precomp_sel_o(pre),
		.step_o(step_w), .drive_sel_o(dsel), .motor_on_o(mot_w), .direction_o(dir_w),
		.side_sel_o(side_w), .third_ctrl_o(third)
	);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Pins drawn from r[31:24]: index, track zero, ready, switches, protect
	function automatic logic [7:0] sense(input logic [31:0] r);
		return {r[31], r[30], r[29], r[28:25], r[24]};
	endfunction : sense

	task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		rd_i <= ~w;
		wr_i <= w;
		@(posedge clk_i);
		rd_i <= 1'b0;
		wr_i <= 1'b0;
		cyc = 0;
		while (ack_o !== 1'b1 && cyc < 3000) begin
			@(posedge clk_i);
			cyc++;
		end
		if (cyc >= 3000)
			mismatches++;
		q = rdata_o;
	endtask : bus

	task close_out;
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out

	initial begin
		#960000;
		mismatches++;
		close_out();
	end

	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b1, 16'hE903, 8'h82);
		bus(1'b1, 16'hEA03, 8'h90);
		bus(1'b0, 16'hEA00, 8'h00);
		chk("sense2 reset", q, 8'h02);
		bus(1'b0, 16'hE000, 8'h00);
		chk("rom low", q, 8'hFF);
		bus(1'b0, 16'hE7FF, 8'h00);
		chk("rom high", q, 8'hFF);
		for (k = 0; k < 6; k++) begin
			rnd = lfsr(rnd);
			{idx_n, tz_n, rdy_n, opt, wp_n} <= rnd[31:24];
			bus(1'b1, 16'hE900, rnd[7:0] & 8'hEF);
			chk("sync", {7'h0, sync_w}, {7'h0, rnd[2]});
			chk("precomp", {6'h0, pre}, {6'h0, rnd[6:5]});
			bus(1'b1, 16'hE902, rnd[15:8]);
			chk("motion", {2'h0, dir_w, mot_w, dsel[2:0], step_w}, {2'h0, rnd[13:8]});
			bus(1'b1, 16'hEA02, {rnd[23], 3'h0, rnd[19], 2'h0, rnd[16]});
			chk("density", {side_w, 4'h0, fmt, dsel[3]}, {rnd[23], 5'h0, rnd[19], rnd[16]});
			bus(1'b1, {8'hE8, rnd[31:24]}, rnd[15:8]);
			bus(1'b0, {8'hE8, rnd[31:24]}, 8'h00);
			chk("ram", q, rnd[15:8]);
			bus(1'b0, 16'hE901, 8'h00);
			chk("sense1", q, sense(rnd));
		end
		bus(1'b1, 16'hEF00, rnd[7:0]);
		bus(1'b0, 16'hEA00, 8'h00);
		chk("head on", {7'h0, q[0]}, 8'h01);
		repeat (60) @(posedge clk_i);
		bus(1'b0, 16'hEA00, 8'h00);
		chk("head off", {7'h0, q[0]}, 8'h00);
		k = 0;
		pr = ref_w;
		repeat (1000) begin
			@(posedge clk_i);
			if (ref_w && !pr)
				k++;
			pr = ref_w;
		end
		chk("ref rate", 8'(k >= 79 && k <= 81), 8'h01);
		// Mark pattern 0110 reads the same either way round
		bus(1'b1, 16'hE900, 8'h00);
		bus(1'b1, 16'hE902, 8'h40);
		bus(1'b1, 16'hEA01, 8'h01);
		chk("third", third, 8'h01);
		bus(1'b1, 16'hEA02, 8'h00);
		rnd = lfsr(rnd);
		fork
			begin
				repeat (4) @(posedge clk_i);
				#7 sep.send(8'hF6, rnd[7:0]);
				sep.send(8'hFF, rnd[15:8]);
			end
		join_none
		bus(1'b0, 16'hEB00, 8'h00);
		chk("mark byte", q, rnd[7:0]);
		bus(1'b0, 16'hED00, 8'h00);
		chk("next byte", q, rnd[15:8]);
		// Sixteen ones from an all-ones preset leave a zero remainder
		bus(1'b1, 16'hE900, 8'h01);
		bus(1'b1, 16'hE902, 8'h80);
		#7 sep.send(8'hFF, 8'hFF);
		sep.send(8'hFF, 8'hFF);
		repeat (4) @(posedge clk_i);
		bus(1'b0, 16'hEA00, 8'h00);
		chk("crc good", {7'h0, q[1]}, 8'h00);
		bus(1'b1, 16'hE902, 8'h80);
		bus(1'b0, 16'hEA00, 8'h00);
		chk("crc preset", {7'h0, q[1]}, 8'h01);
		fork
			begin
				repeat (10) @(posedge clk_i);
				chk("wait level", {7'h0, wait_o}, 8'h01);
			end
		join_none
		bus(1'b0, 16'hED00, 8'h00);
		chk("stall data", q, 8'hFF);
		chk("stall len", 8'(cyc > 1900 && cyc < 2100), 8'h01);
		bus(1'b1, 16'hE900, 8'h10);
		chk("gate", {7'h0, wg_w}, 8'h01);
		bus(1'b1, 16'hEE00, rnd[23:16]);
		bus(1'b1, 16'hEE00, rnd[31:24]);
		chk("write stall", 8'(cyc > 1 && cyc < 1900), 8'h01);
		// First byte goes out MSB first, one FM cell per bit
		for (k = 7; k >= 0; k--) begin
			chk("write data", {7'h0, wd_w}, {7'h0, rnd[16 + k]});
			repeat (fdcp_pkg::FM_BIT_CYC) @(posedge clk_i);
		end
		close_out();
	end
endmodule : tb
